// ### beat_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Synchronous clear empties it in one edge
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             clear,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    wr_next;
   logic [AW-1:0]    rd_reg;
   logic [AW-1:0]    rd_next;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_next  = wr_reg + AW'(push);
      rd_next  = rd_reg + AW'(pop);
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (clear) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset; occupancy gates every read
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ### bus_master_model.sv
// Purpose: Behavioural bus initiator driving the target pins
// Assumes: Pins change on the falling edge
// Notes:   Released lines toggle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input  wire logic        sys_clk,
   output logic             frame_n,
   output logic             irdy_n,
   output logic      [31:0] ad,
   output logic      [3:0]  cbe_n,
   output logic             par
);
   logic flip;

   initial begin
      frame_n = 1'b1;
      irdy_n  = 1'b1;
      ad      = 32'h0;
      cbe_n   = 4'h0;
      flip    = 1'b0;
      par     = 1'b0;
   end

   // Parity covers the previous pin cycle, flipped on request
   always @(negedge sys_clk) par <= ^{ad, cbe_n} ^ flip;

   task automatic txn(input logic [3:0] cmd, input logic [31:0] addr, input int n,
                      input logic [31:0] d0, input logic [3:0] be_n, input logic bad);
      @(negedge sys_clk);
      frame_n <= 1'b0;
      ad      <= addr;
      cbe_n   <= cmd;
      flip    <= bad;
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         frame_n <= (i == n - 1);
         irdy_n  <= 1'b0;
         ad      <= cmd[0] ? d0 + i : ~ad;
         cbe_n   <= be_n ^ (cmd[0] ? i[3:0] : 4'h0);
      end
      @(negedge sys_clk);
      frame_n <= 1'b1;
      irdy_n  <= 1'b1;
      ad      <= ~ad;
      cbe_n   <= ~cbe_n;
      flip    <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### pci_sig_pkg.sv
// Purpose: Shared constants and types for the bus target signal layer
// Assumes: Four-bit command field, 32-bit multiplexed address/data
// Notes:   Command codes are those of the shared command/byte-enable lines
package pci_sig_pkg;

   // ----------------------------------------
   // Widths and sizes
   // ----------------------------------------
   localparam int AD_W       = 32;
   localparam int CBE_W      = 4;
   localparam int FIFO_DEPTH = 4;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [3:0] CMD_INT_ACK   = 4'h0;
   localparam logic [3:0] CMD_SPECIAL   = 4'h1;
   localparam logic [3:0] CMD_IO_RD     = 4'h2;
   localparam logic [3:0] CMD_IO_WR     = 4'h3;
   localparam logic [3:0] CMD_MEM_RD    = 4'h6;
   localparam logic [3:0] CMD_MEM_WR    = 4'h7;
   localparam logic [3:0] CMD_CFG_RD    = 4'ha;
   localparam logic [3:0] CMD_CFG_WR    = 4'hb;
   localparam logic [3:0] CMD_MEM_RD_M  = 4'hc;
   localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
   localparam logic [3:0] CMD_MEM_RD_L  = 4'he;
   localparam logic [3:0] CMD_MEM_WR_I  = 4'hf;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      SPACE_NONE = 3'b000,
      SPACE_IO   = 3'b001,
      SPACE_MEM  = 3'b010,
      SPACE_CFG  = 3'b011
   } space_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0]  cmd;
      space_t      space;
      logic        is_write;
   } addr_info_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  be;
      logic        is_write;
   } beat_t;

   localparam int BEAT_W = $bits(beat_t);

endpackage

// ### pci_target_signal_layer.sv
// Purpose: Target-side signal layer: phases, command decode, parity
// Assumes: Bus pins sampled on sys_clk rising edge; handshake out of scope
// Notes:   Write beats flow to user side through a 4-word FIFO
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Address and data share 32 lines
// - First frame cycle is address phase
// - Data phase on each initiator-ready cycle
// - Decode I/O read and write commands
// - Decode configuration read and write
// - Decode the three memory read commands
// - Memory write and invalidate counts as write
// - Data phase lines are active-low byte enables
// - Parity even over data, commands, parity
// - Read parity trails data by one clock
// - All bus signals registered on rising edge
// - Fully static, up to 33 MHz
// - Reset tri-states all bus outputs
// - Reset floats open-drain outputs
// - Reset restores register defaults
// - Reset idles channel and empties FIFOs
// - Special cycles are ignored
module pci_target_signal_layer (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Bus side
   input  wire logic [31:0] ad_in,
   output logic      [31:0] ad_out,
   output logic             ad_oe,
   input  wire logic [3:0]  cbe_n_in,
   input  wire logic        frame_n_in,
   input  wire logic        irdy_n_in,
   input  wire logic        par_in,
   output logic             par_out,
   output logic             par_oe,
   output logic             sys_err_n_out,
   output logic             sys_err_n_oe,
   // Decoded address phase
   output pci_sig_pkg::addr_info_t addr_info,
   output logic             addr_claim,
   output logic             addr_par_err,
   output logic             data_par_err,
   // Write beats toward user logic
   output logic             wr_valid,
   input  wire logic        wr_ready,
   output pci_sig_pkg::beat_t wr_beat,
   output logic             wr_overflow,
   // Read data from user logic
   input  wire logic        rd_drive,
   input  wire logic [31:0] rd_data
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Two stages keep this clock domain safe from the pins
   logic [31:0] ad_s1_reg;
   logic [31:0] ad_s2_reg;
   logic [3:0]  cbe_s1_reg;
   logic [3:0]  cbe_s2_reg;
   logic [2:0]  ctl_s1_reg;
   logic [2:0]  ctl_s2_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ad_s1_reg  <= '0;
         ad_s2_reg  <= '0;
         cbe_s1_reg <= '1;
         cbe_s2_reg <= '1;
         ctl_s1_reg <= '1;
         ctl_s2_reg <= '1;
      end else begin
         ad_s1_reg  <= ad_in;
         ad_s2_reg  <= ad_s1_reg;
         cbe_s1_reg <= cbe_n_in;
         cbe_s2_reg <= cbe_s1_reg;
         ctl_s1_reg <= {frame_n_in, irdy_n_in, par_in};
         ctl_s2_reg <= ctl_s1_reg;
      end
   end

   logic frame_s;
   logic irdy_s;
   logic par_s;
   assign frame_s = !ctl_s2_reg[2];
   assign irdy_s  = !ctl_s2_reg[1];
   assign par_s   = ctl_s2_reg[0];

   // ----------------------------------------
   // Phase tracking and decode
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01
   } phase_t;

   phase_t                 st_reg;
   phase_t                 st_next;
   pci_sig_pkg::addr_info_t info_reg;
   pci_sig_pkg::addr_info_t info_next;
   logic                   claim_reg;
   logic                   claim_next;
   logic                   claim_pulse_reg;
   logic                   claim_pulse_next;
   logic                   apar_chk_reg;
   logic                   apar_chk_next;
   logic                   dpar_chk_reg;
   logic                   dpar_chk_next;
   logic [35:0]            prev_reg;
   logic [35:0]            prev_next;
   logic                   aerr_reg;
   logic                   aerr_next;
   logic                   derr_reg;
   logic                   derr_next;
   logic                   addr_phase;
   logic                   data_phase;
   pci_sig_pkg::space_t    dec_space;
   logic                   dec_write;

   assign addr_phase = (st_reg == ST_IDLE) && frame_s;
   assign data_phase = (st_reg == ST_DATA) && irdy_s;

   always_comb begin
      dec_space = pci_sig_pkg::SPACE_NONE;
      dec_write = 1'b0;
      unique case (cbe_s2_reg)
         pci_sig_pkg::CMD_IO_RD: dec_space = pci_sig_pkg::SPACE_IO;
         pci_sig_pkg::CMD_IO_WR: begin
            dec_space = pci_sig_pkg::SPACE_IO;
            dec_write = 1'b1;
         end
         pci_sig_pkg::CMD_CFG_RD: dec_space = pci_sig_pkg::SPACE_CFG;
         pci_sig_pkg::CMD_CFG_WR: begin
            dec_space = pci_sig_pkg::SPACE_CFG;
            dec_write = 1'b1;
         end
         pci_sig_pkg::CMD_MEM_RD,
         pci_sig_pkg::CMD_MEM_RD_M,
         pci_sig_pkg::CMD_MEM_RD_L: dec_space = pci_sig_pkg::SPACE_MEM;
         pci_sig_pkg::CMD_MEM_WR,
         pci_sig_pkg::CMD_MEM_WR_I: begin
            dec_space = pci_sig_pkg::SPACE_MEM;
            dec_write = 1'b1;
         end
         // Special, acknowledge, dual address and reserved stay unclaimed
         default: dec_space = pci_sig_pkg::SPACE_NONE;
      endcase
   end

   always_comb begin
      st_next          = st_reg;
      info_next        = info_reg;
      claim_next       = claim_reg;
      claim_pulse_next = 1'b0;
      apar_chk_next    = 1'b0;
      dpar_chk_next    = 1'b0;
      prev_next        = {cbe_s2_reg, ad_s2_reg};
      aerr_next        = 1'b0;
      derr_next        = 1'b0;
      unique case (st_reg)
         ST_IDLE: begin
            if (addr_phase) begin
               st_next            = ST_DATA;
               info_next.addr     = ad_s2_reg;
               info_next.cmd      = cbe_s2_reg;
               info_next.space    = dec_space;
               info_next.is_write = dec_write;
               claim_next         = (dec_space != pci_sig_pkg::SPACE_NONE);
               claim_pulse_next   = claim_next;
               apar_chk_next      = 1'b1;
            end
         end
         ST_DATA: begin
            // Frame and ready both deasserted close the transaction
            if (!frame_s && !irdy_s) begin
               st_next    = ST_IDLE;
               claim_next = 1'b0;
            end
            dpar_chk_next = data_phase && info_reg.is_write && claim_reg;
         end
      endcase
      // Parity covering last cycle arrives one clock later
      if (apar_chk_reg) begin
         aerr_next = ^{prev_reg, par_s};
      end
      if (dpar_chk_reg) begin
         derr_next = ^{prev_reg, par_s};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_reg          <= ST_IDLE;
         info_reg        <= '0;
         claim_reg       <= 1'b0;
         claim_pulse_reg <= 1'b0;
         apar_chk_reg    <= 1'b0;
         dpar_chk_reg    <= 1'b0;
         prev_reg        <= '0;
         aerr_reg        <= 1'b0;
         derr_reg        <= 1'b0;
      end else begin
         st_reg          <= st_next;
         info_reg        <= info_next;
         claim_reg       <= claim_next;
         claim_pulse_reg <= claim_pulse_next;
         apar_chk_reg    <= apar_chk_next;
         dpar_chk_reg    <= dpar_chk_next;
         prev_reg        <= prev_next;
         aerr_reg        <= aerr_next;
         derr_reg        <= derr_next;
      end
   end

   assign addr_info    = info_reg;
   assign addr_claim   = claim_pulse_reg;
   assign addr_par_err = aerr_reg;
   assign data_par_err = derr_reg;

   // ----------------------------------------
   // Write beats into the FIFO
   // ----------------------------------------
   pci_sig_pkg::beat_t in_beat;
   logic               in_valid;
   logic               in_ready;
   logic               ovf_reg;
   logic               ovf_next;

   always_comb begin
      in_beat.data     = ad_s2_reg;
      in_beat.be       = ~cbe_s2_reg;
      in_beat.is_write = 1'b1;
      in_valid         = data_phase && info_reg.is_write && claim_reg;
      // Pins cannot be stalled here, so a full FIFO loses the beat
      ovf_next         = in_valid && !in_ready;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ovf_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
      end
   end

   assign wr_overflow = ovf_reg;

   logic [pci_sig_pkg::BEAT_W-1:0] out_bits;

   beat_fifo #(
      .WIDTH (pci_sig_pkg::BEAT_W),
      .DEPTH (pci_sig_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clear     (1'b0),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_beat),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (out_bits)
   );

   assign wr_beat = pci_sig_pkg::beat_t'(out_bits);

   // ----------------------------------------
   // Read data and trailing parity drive
   // ----------------------------------------
   logic [31:0] ad_out_reg;
   logic [31:0] ad_out_next;
   logic        ad_oe_reg;
   logic        ad_oe_next;
   logic        par_reg;
   logic        par_next;
   logic        par_oe_reg;
   logic        par_oe_next;

   always_comb begin
      ad_oe_next  = rd_drive && claim_reg && !info_reg.is_write
                    && (st_reg == ST_DATA);
      ad_out_next = ad_oe_next ? rd_data : '0;
      // Parity of the word on the lines now, driven next clock
      par_next    = ^{ad_out_reg, cbe_s2_reg};
      par_oe_next = ad_oe_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ad_out_reg <= '0;
         ad_oe_reg  <= 1'b0;
         par_reg    <= 1'b0;
         par_oe_reg <= 1'b0;
      end else begin
         ad_out_reg <= ad_out_next;
         ad_oe_reg  <= ad_oe_next;
         par_reg    <= par_next;
         par_oe_reg <= par_oe_next;
      end
   end

   assign ad_out        = ad_out_reg;
   assign ad_oe         = ad_oe_reg;
   assign par_out       = par_reg;
   assign par_oe        = par_oe_reg;
   // No system error source here; line stays released
   assign sys_err_n_out = 1'b0;
   assign sys_err_n_oe  = 1'b0;
endmodule
`default_nettype wire

// ### target_port_monitor.sv
// Purpose: Port checks on the bus target signal layer
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module target_port_monitor (
   input wire logic                       sys_clk,
   input wire logic                       rst_n,
   input wire logic [31:0]                ad_out,
   input wire logic                       ad_oe,
   input wire logic                       par_oe,
   input wire logic                       sys_err_n_oe,
   input wire pci_sig_pkg::addr_info_t    addr_info,
   input wire logic                       addr_claim,
   input wire logic                       wr_valid,
   input wire logic                       wr_ready,
   input wire logic                       wr_overflow,
   input wire logic                       rd_drive,
   input wire logic [31:0]                rd_data
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_err_float: assert property (!sys_err_n_oe)
      else $error("error line driven");
   // Reset itself is the cause here, so it cannot disable the check
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n |=> !ad_oe && !par_oe && !wr_valid)
      else $error("outputs active after reset");
   a_par_trails: assert property (ad_oe |=> par_oe)
      else $error("read parity missing");
   a_par_cause: assert property (par_oe |-> $past(ad_oe))
      else $error("parity without read data");
   a_read_data: assert property (ad_oe |-> $past(rd_drive) && ad_out == $past(rd_data))
      else $error("read data wrong");
   a_claim_once: assert property (addr_claim |=> !addr_claim)
      else $error("claim longer than a cycle");
   a_claim_legal: assert property (addr_claim |-> addr_info.cmd inside
      {4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf})
      else $error("unsupported command claimed");
   a_claim_dir: assert property (addr_claim |-> addr_info.is_write == addr_info.cmd[0])
      else $error("direction wrong");
   a_claim_space: assert property (addr_claim |-> addr_info.space ==
      (addr_info.cmd[3:1] == 3'h1 ? pci_sig_pkg::SPACE_IO :
       addr_info.cmd[3:1] == 3'h5 ? pci_sig_pkg::SPACE_CFG : pci_sig_pkg::SPACE_MEM))
      else $error("space wrong");
   a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid)
      else $error("write beat vanished");
   a_ovf_full: assert property (wr_overflow |-> $past(wr_valid))
      else $error("overflow with room left");

   c_claim: cover property (addr_claim);
   c_ovf: cover property (wr_overflow);
   c_read: cover property (ad_oe ##1 par_oe);
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the target signal layer
// Assumes: Inputs change on the falling edge
// Notes:   Pulse outputs are counted on the rising edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                    sys_clk, rst_n, wr_ready, rd_drive;
   logic [31:0]             rd_data, ad_out, mst_ad, ad_bus;
   logic [3:0]              cbe_n;
   logic                    frame_n, irdy_n, mst_par, par_bus, par_out, par_oe, ad_oe;
   logic                    sys_err_n_out, sys_err_n_oe, addr_claim, wr_valid, wr_overflow;
   logic                    addr_par_err, data_par_err;
   pci_sig_pkg::addr_info_t addr_info, info_seen;
   pci_sig_pkg::beat_t      wr_beat;
   int                      err_total, samples_checked, claims, ovfs, apes, dpes;

   assign ad_bus  = ad_oe ? ad_out : mst_ad;
   assign par_bus = par_oe ? par_out : mst_par;

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   bus_master_model i_mst (.sys_clk(sys_clk), .frame_n(frame_n), .irdy_n(irdy_n),
                           .ad(mst_ad), .cbe_n(cbe_n), .par(mst_par));
   pci_target_signal_layer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ad_in(ad_bus),
      .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_in(cbe_n), .frame_n_in(frame_n),
      .irdy_n_in(irdy_n), .par_in(par_bus), .par_out(par_out), .par_oe(par_oe),
      .sys_err_n_out(sys_err_n_out), .sys_err_n_oe(sys_err_n_oe), .addr_info(addr_info),
      .addr_claim(addr_claim), .addr_par_err(addr_par_err), .data_par_err(data_par_err),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat),
      .wr_overflow(wr_overflow), .rd_drive(rd_drive), .rd_data(rd_data));

   always @(posedge sys_clk) begin
      if (addr_claim === 1'b1) begin
         claims++;
         info_seen = addr_info;
      end
      if (wr_overflow === 1'b1) ovfs++;
      if (addr_par_err === 1'b1) apes++;
      if (data_par_err === 1'b1) dpes++;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic summarize;
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   // Bounded wait on claim (sel 0) or read drive (sel 1); running out ends the run
   task automatic wait_until(input bit sel);
      for (int i = 0; i < 20 && (sel ? ad_oe : addr_claim) !== 1'b1; i++) @(negedge sys_clk);
      if ((sel ? ad_oe : addr_claim) !== 1'b1) begin
         chk(1'b0, "wait ran out");
         summarize();
      end
   endtask

   task automatic clr;
      claims = 0;
      ovfs   = 0;
      apes   = 0;
      dpes   = 0;
   endtask

   // Extra edge keeps two pops from toggling ready in one time step
   task automatic pop;
      wr_ready = 1'b1;
      @(negedge sys_clk);
      wr_ready = 1'b0;
      @(negedge sys_clk);
   endtask

   function automatic pci_sig_pkg::space_t exp_space(input logic [3:0] c);
      case (c)
         4'h2, 4'h3:                      return pci_sig_pkg::SPACE_IO;
         4'ha, 4'hb:                      return pci_sig_pkg::SPACE_CFG;
         4'h6, 4'h7, 4'hc, 4'he, 4'hf:    return pci_sig_pkg::SPACE_MEM;
         default:                         return pci_sig_pkg::SPACE_NONE;
      endcase
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_quiet;
      chk({ad_oe, par_oe, sys_err_n_oe, wr_valid, addr_claim, wr_overflow} === 6'h00,
          "outputs not idle in reset");
      chk({addr_par_err, data_par_err, sys_err_n_out, ad_out, par_out} === '0,
          "outputs not zero in reset");
      chk(addr_info === '0, "decode not cleared in reset");
   endtask

   task automatic t_cmds;
      pci_sig_pkg::space_t sp;
      for (int c = 0; c < 16; c++) begin
         clr();
         sp = exp_space(c[3:0]);
         i_mst.txn(c[3:0], 32'h1000_0000 + c, 1, 32'h5a00_0000 + c, 4'h0, 1'b0);
         repeat (8) @(negedge sys_clk);
         chk(claims == (sp != pci_sig_pkg::SPACE_NONE), "claim wrong");
         if (sp != pci_sig_pkg::SPACE_NONE) begin
            chk(info_seen === {32'h1000_0000 + c, c[3:0], sp, c[0]}, "info");
         end
         chk(wr_valid === (sp != pci_sig_pkg::SPACE_NONE && c[0]), "beat presence");
         if (wr_valid === 1'b1) begin
            chk(wr_beat === {32'h5a00_0000 + c, 4'hf, 1'b1}, "beat data");
            pop();
         end
      end
   endtask

   task automatic t_overflow;
      clr();
      i_mst.txn(pci_sig_pkg::CMD_MEM_WR, 32'h3000_0000, 6, 32'hc0de_0000, 4'h5, 1'b0);
      repeat (8) @(negedge sys_clk);
      chk(ovfs == 2, "overflow count");
      chk(apes + dpes == 0, "false parity error");
      for (int i = 0; i < 4; i++) begin
         chk(wr_valid === 1'b1, "beat missing");
         chk(wr_beat === {32'hc0de_0000 + i, ~(4'h5 ^ i[3:0]), 1'b1}, "burst beat");
         pop();
      end
      chk(wr_valid === 1'b0, "fifo not empty");
   endtask

   task automatic t_read;
      clr();
      fork
         i_mst.txn(pci_sig_pkg::CMD_MEM_RD, 32'h2000_0040, 8, 32'h0, 4'h3, 1'b0);
         begin
            wait_until(1'b0);
            rd_data  = 32'h8765_4321;
            rd_drive = 1'b1;
            @(negedge sys_clk);
            rd_drive = 1'b0;
            wait_until(1'b1);
            chk(ad_out === 32'h8765_4321, "read data");
            @(negedge sys_clk);
            chk(par_oe === 1'b1 && par_out === ^{32'h8765_4321, 4'h3}, "read parity");
         end
      join
      repeat (4) @(negedge sys_clk);
   endtask

   task automatic t_par_err;
      clr();
      i_mst.txn(pci_sig_pkg::CMD_MEM_WR, 32'h4000_0000, 1, 32'h0f0f_0f0f, 4'h0, 1'b1);
      repeat (8) @(negedge sys_clk);
      chk(apes == 1, "address parity error");
      chk(dpes == 1, "data parity error");
      if (wr_valid === 1'b1) pop();
   endtask

   task automatic t_reset_mid;
      i_mst.txn(pci_sig_pkg::CMD_MEM_WR, 32'h5000_0000, 3, 32'h1111_0000, 4'h0, 1'b0);
      repeat (8) @(negedge sys_clk);
      chk(wr_valid === 1'b1, "beats not queued");
      rst_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_quiet();
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(wr_valid === 1'b0, "fifo kept beats");
   endtask

   initial begin
      rst_n           = 1'b0;
      wr_ready        = 1'b0;
      rd_drive        = 1'b0;
      rd_data         = 32'h0;
      err_total       = 0;
      samples_checked = 0;
      clr();
      repeat (20) @(negedge sys_clk);
      t_quiet();
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_cmds();
      t_overflow();
      t_read();
      t_par_err();
      t_reset_mid();
      summarize();
   end
endmodule

bind pci_target_signal_layer target_port_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
   .ad_out(ad_out), .ad_oe(ad_oe), .par_oe(par_oe), .sys_err_n_oe(sys_err_n_oe),
   .addr_info(addr_info), .addr_claim(addr_claim), .wr_valid(wr_valid),
   .wr_ready(wr_ready), .wr_overflow(wr_overflow), .rd_drive(rd_drive), .rd_data(rd_data));
`default_nettype wire
